/* File: verilog/cmp_out_pkg.sv */
// Purpose: Shared constants and types for the compare-output block
// Assumes: 16-bit timer, APB register access, 100 MHz pclk
// Notes:   Offsets are byte addresses of aligned 32-bit words
package cmp_out_pkg;

  localparam logic [11:0] ctrl_off       = 12'h000;
  localparam logic [11:0] force_off      = 12'h004;
  localparam logic [11:0] cmp_a_off      = 12'h008;
  localparam logic [11:0] cmp_b_off      = 12'h00C;
  localparam logic [11:0] status_off     = 12'h010;

  // Control register fields
  localparam int ctrl_wgm_lsb            = 0;
  localparam int ctrl_mode_a_lsb         = 4;
  localparam int ctrl_mode_b_lsb         = 6;
  // Force register fields
  localparam int force_a_bit             = 3;
  localparam int force_b_bit             = 2;
  // Status register fields
  localparam int stat_wave_a_bit         = 0;
  localparam int stat_wave_b_bit         = 1;
  localparam int stat_en_a_bit           = 2;
  localparam int stat_en_b_bit           = 3;
  localparam int stat_dir_bit            = 4;

  localparam logic [3:0]  wgm_reset      = 4'h0;
  localparam logic [1:0]  mode_reset     = 2'h0;
  localparam logic [15:0] cmp_reset      = 16'h0000;
  localparam logic [15:0] bottom_val     = 16'h0000;
  localparam logic [3:0]  wgm_toggle_fast = 4'hF;
  localparam logic [3:0]  wgm_toggle_pc0  = 4'h9;
  localparam logic [3:0]  wgm_toggle_pc1  = 4'hE;

  localparam logic [1:0]  mode_off       = 2'h0;
  localparam logic [1:0]  mode_toggle    = 2'h1;
  localparam logic [1:0]  mode_clear     = 2'h2;
  localparam logic [1:0]  mode_set       = 2'h3;

  typedef enum logic [1:0] {
    kind_normal,
    kind_fast,
    kind_phase
  } wave_kind_t;

  typedef struct packed {
    logic [15:0] count;
    logic        match_a;
    logic        match_b;
    logic        count_down;
  } timer_state_t;

  typedef struct packed {
    logic wave_a;
    logic wave_b;
    logic override_a;
    logic override_b;
  } wave_out_t;

endpackage

/* File: verilog/cmp_channel.sv */
// Purpose: One compare-output channel waveform register
// Assumes: Events arrive as one-cycle pulses on pclk
// Notes:   Channel A alone may use the toggle mode
`timescale 1ns/100ps
module cmp_channel
  import cmp_out_pkg::*;
#(
  parameter bit is_chan_a = 1'b1
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Configuration
  input  wire wave_kind_t  kind,
  input  wire logic [3:0]  waveform_select,
  input  wire logic [1:0]  out_mode_field,
  input  wire logic [15:0] compare_value,
  input  wire logic [15:0] top_value,
  // Events
  input  wire logic        match,
  input  wire logic        at_bottom,
  input  wire logic        count_down,
  input  wire logic        force_strobe,
  // Output
  output      logic        wave_q,
  output      logic        override
);

  logic toggle_ok;
  logic cmp_hit;
  logic wave_d;

  always_comb begin
    unique case (kind)
      kind_fast:  toggle_ok = is_chan_a &&
                              (waveform_select == wgm_toggle_fast);
      kind_phase: toggle_ok = is_chan_a &&
                              (waveform_select == wgm_toggle_pc0 ||
                               waveform_select == wgm_toggle_pc1);
      default:    toggle_ok = is_chan_a;
    endcase
  end

  // Pin override follows the mode field
  always_comb begin
    if (out_mode_field == mode_off) begin
      override = 1'b0;
    end else if (out_mode_field == mode_toggle) begin
      override = toggle_ok;
    end else begin
      override = 1'b1;
    end
  end

  always_comb begin
    // Forced match only in non-PWM modes
    cmp_hit = match || (force_strobe && kind == kind_normal);
    // Ignore match at TOP in fast PWM with upper mode bit set
    if (kind == kind_fast && out_mode_field[1] &&
        compare_value == top_value) begin
      cmp_hit = 1'b0;
    end
  end

  always_comb begin
    wave_d = wave_q;
    unique case (out_mode_field)
      mode_off: wave_d = wave_q;
      mode_toggle: begin
        if (cmp_hit && toggle_ok) begin
          wave_d = ~wave_q;
        end
      end
      mode_clear: begin
        if (kind == kind_fast) begin
          if (cmp_hit) begin
            wave_d = 1'b0;
          end else if (at_bottom) begin
            wave_d = 1'b1;
          end
        end else if (kind == kind_phase) begin
          if (cmp_hit) begin
            wave_d = count_down;
          end
        end else if (cmp_hit) begin
          wave_d = 1'b0;
        end
      end
      mode_set: begin
        if (kind == kind_fast) begin
          if (cmp_hit) begin
            wave_d = 1'b1;
          end else if (at_bottom) begin
            wave_d = 1'b0;
          end
        end else if (kind == kind_phase) begin
          if (cmp_hit) begin
            wave_d = ~count_down;
          end
        end else if (cmp_hit) begin
          wave_d = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_q <= 1'b0;
    end else begin
      wave_q <= wave_d;
    end
  end

endmodule

/* File: verilog/timer_cmp_out.sv */
// Purpose: Compare-output waveform control with APB registers
// Assumes: Timer counter, matches and direction come from pclk logic
// Notes:   APB answers with zero wait states
`timescale 1ns/100ps
module timer_cmp_out
  import cmp_out_pkg::*;
(
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // Timer state
  input  wire timer_state_t tstate,
  input  wire logic [15:0] icr_top,
  // Waveform outputs
  output      wave_out_t   wout,
  // Counter side effects
  output      logic        match_flag_a,
  output      logic        match_flag_b,
  output      logic        counter_clear
);

  logic [3:0]  waveform_select_q;
  logic [1:0]  out_mode_a_q;
  logic [1:0]  out_mode_b_q;
  logic [15:0] compare_value_a_q;
  logic [15:0] compare_value_b_q;
  logic        force_compare_a;
  logic        force_compare_b;
  logic [31:0] prdata_d;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [15:0] top_value;
  logic        at_bottom;
  wave_kind_t  kind;

  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign addr_ok = (paddr == ctrl_off) || (paddr == force_off) ||
                   (paddr == cmp_a_off) || (paddr == cmp_b_off) ||
                   (paddr == status_off);
  assign pslverr = psel && penable && !addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      waveform_select_q <= wgm_reset;
      out_mode_a_q      <= mode_reset;
      out_mode_b_q      <= mode_reset;
    end else if (wr_en && paddr == ctrl_off) begin
      waveform_select_q <= pwdata[ctrl_wgm_lsb +: 4];
      out_mode_a_q      <= pwdata[ctrl_mode_a_lsb +: 2];
      out_mode_b_q      <= pwdata[ctrl_mode_b_lsb +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_value_a_q <= cmp_reset;
      compare_value_b_q <= cmp_reset;
    end else if (wr_en && paddr == cmp_a_off) begin
      compare_value_a_q <= pwdata[15:0];
    end else if (wr_en && paddr == cmp_b_off) begin
      compare_value_b_q <= pwdata[15:0];
    end
  end

  // Force strobes live only in the write cycle
  assign force_compare_a = wr_en && (paddr == force_off) &&
                           pwdata[force_a_bit];
  assign force_compare_b = wr_en && (paddr == force_off) &&
                           pwdata[force_b_bit];

  always_comb begin
    prdata_d = 32'h0000_0000;
    unique case (paddr)
      ctrl_off: begin
        prdata_d[ctrl_wgm_lsb +: 4]    = waveform_select_q;
        prdata_d[ctrl_mode_a_lsb +: 2] = out_mode_a_q;
        prdata_d[ctrl_mode_b_lsb +: 2] = out_mode_b_q;
      end
      force_off:  prdata_d = 32'h0000_0000;
      cmp_a_off:  prdata_d[15:0] = compare_value_a_q;
      cmp_b_off:  prdata_d[15:0] = compare_value_b_q;
      status_off: begin
        prdata_d[stat_wave_a_bit] = wout.wave_a;
        prdata_d[stat_wave_b_bit] = wout.wave_b;
        prdata_d[stat_en_a_bit]   = wout.override_a;
        prdata_d[stat_en_b_bit]   = wout.override_b;
        prdata_d[stat_dir_bit]    = tstate.count_down;
      end
      default:    prdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= prdata_d;
    end
  end

  // Waveform class and TOP from the select
  always_comb begin
    kind      = kind_normal;
    top_value = 16'hFFFF;
    unique case (waveform_select_q)
      4'h1, 4'h2, 4'h3, 4'hA, 4'hB, 4'h8, 4'h9: kind = kind_phase;
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF:             kind = kind_fast;
      default:                                  kind = kind_normal;
    endcase
    unique case (waveform_select_q)
      4'h1, 4'h5:               top_value = 16'h00FF;
      4'h2, 4'h6:               top_value = 16'h01FF;
      4'h3, 4'h7:               top_value = 16'h03FF;
      4'h4, 4'h9, 4'hB, 4'hF:   top_value = compare_value_a_q;
      4'h8, 4'hA, 4'hC, 4'hE:   top_value = icr_top;
      default:                  top_value = 16'hFFFF;
    endcase
  end

  assign at_bottom = (tstate.count == bottom_val);

  // Flags and counter clear see only real matches
  assign match_flag_a = tstate.match_a;
  assign match_flag_b = tstate.match_b;
  assign counter_clear = tstate.match_a &&
                         (waveform_select_q == 4'h4);

  cmp_channel #(
    .is_chan_a      (1'b1)
  ) u_chan_a (
    .pclk           (pclk),
    .presetn        (presetn),
    .kind           (kind),
    .waveform_select(waveform_select_q),
    .out_mode_field (out_mode_a_q),
    .compare_value  (compare_value_a_q),
    .top_value      (top_value),
    .match          (tstate.match_a),
    .at_bottom      (at_bottom),
    .count_down     (tstate.count_down),
    .force_strobe   (force_compare_a),
    .wave_q         (wout.wave_a),
    .override       (wout.override_a)
  );

  cmp_channel #(
    .is_chan_a      (1'b0)
  ) u_chan_b (
    .pclk           (pclk),
    .presetn        (presetn),
    .kind           (kind),
    .waveform_select(waveform_select_q),
    .out_mode_field (out_mode_b_q),
    .compare_value  (compare_value_b_q),
    .top_value      (top_value),
    .match          (tstate.match_b),
    .at_bottom      (at_bottom),
    .count_down     (tstate.count_down),
    .force_strobe   (force_compare_b),
    .wave_q         (wout.wave_b),
    .override       (wout.override_b)
  );

  a_mode_off_disc: assert property (
    @(posedge pclk) disable iff (!presetn)
    out_mode_b_q == mode_off
    |-> !wout.override_b)
    else $error("channel b driven with mode off");

  a_off_disc_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    out_mode_a_q == mode_off
    |-> !wout.override_a)
    else $error("channel a driven with mode off");

  a_off_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    out_mode_a_q == mode_off
    |=> $stable(wout.wave_a))
    else $error("channel a moved with mode off");

  a_off_hold_b: assert property (
    @(posedge pclk) disable iff (!presetn)
    out_mode_b_q == mode_off
    |=> $stable(wout.wave_b))
    else $error("channel b moved with mode off");

  a_b_no_toggle: assert property (
    @(posedge pclk) disable iff (!presetn)
    out_mode_b_q == mode_toggle
    |-> !wout.override_b)
    else $error("channel b toggle connected");

  a_fast_toggle_en: assert property (
    @(posedge pclk) disable iff (!presetn)
    kind == kind_fast && out_mode_a_q == mode_toggle
    |-> wout.override_a == (waveform_select_q == wgm_toggle_fast))
    else $error("fast toggle enable wrong");

  a_fast_toggle_edge: assert property (
    @(posedge pclk) disable iff (!presetn)
    kind == kind_fast && out_mode_a_q == mode_toggle &&
    waveform_select_q == wgm_toggle_fast && tstate.match_a
    |=> wout.wave_a != $past(wout.wave_a))
    else $error("fast toggle on match missing");

  a_fast_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    kind == kind_fast && out_mode_a_q == mode_clear && tstate.match_a &&
    compare_value_a_q != top_value && $stable(out_mode_a_q)
    |=> !wout.wave_a || $changed(out_mode_a_q))
    else $error("fast clear on match missing");

  a_fast_set_b: assert property (
    @(posedge pclk) disable iff (!presetn)
    kind == kind_fast && out_mode_b_q == mode_clear && at_bottom &&
    !tstate.match_b |=> wout.wave_b)
    else $error("fast set at bottom missing");

  a_fast_bottom: assert property (
    @(posedge pclk) disable iff (!presetn)
    kind == kind_fast && out_mode_a_q == mode_set && at_bottom &&
    !tstate.match_a |=> !wout.wave_a || $changed(out_mode_a_q))
    else $error("fast clear at bottom missing");

  a_fast_set_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    kind == kind_fast && out_mode_a_q == mode_set && tstate.match_a &&
    compare_value_a_q != top_value |=> wout.wave_a)
    else $error("fast set on match missing");

  a_top_skip: assert property (
    @(posedge pclk) disable iff (!presetn)
    kind == kind_fast && out_mode_a_q[1] && !at_bottom &&
    compare_value_a_q == top_value |=> $stable(wout.wave_a))
    else $error("match at top not ignored");

  a_top_bottom: assert property (
    @(posedge pclk) disable iff (!presetn)
    kind == kind_fast && out_mode_a_q == mode_clear && at_bottom &&
    compare_value_a_q == top_value |=> wout.wave_a)
    else $error("bottom set lost with compare at top");

  a_phase_toggle_en: assert property (
    @(posedge pclk) disable iff (!presetn)
    kind == kind_phase && out_mode_a_q == mode_toggle
    |-> wout.override_a == (waveform_select_q == wgm_toggle_pc0 ||
                            waveform_select_q == wgm_toggle_pc1))
    else $error("phase toggle enable wrong");

  a_phase_up: assert property (
    @(posedge pclk) disable iff (!presetn)
    kind == kind_phase && out_mode_b_q == mode_clear && tstate.match_b &&
    !tstate.count_down |=> !wout.wave_b || $changed(out_mode_b_q))
    else $error("phase clear on up match missing");

  a_phase_dn_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    kind == kind_phase && out_mode_a_q == mode_clear && tstate.match_a &&
    tstate.count_down |=> wout.wave_a)
    else $error("phase set on down match missing");

  a_phase_down: assert property (
    @(posedge pclk) disable iff (!presetn)
    kind == kind_phase && out_mode_b_q == mode_set && tstate.match_b &&
    tstate.count_down |=> !wout.wave_b || $changed(out_mode_b_q))
    else $error("phase clear on down match missing");

  a_phase_set_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    kind == kind_phase && out_mode_a_q == mode_set && tstate.match_a &&
    !tstate.count_down |=> wout.wave_a)
    else $error("phase set on up match missing");

  a_force_pwm_nop: assert property (
    @(posedge pclk) disable iff (!presetn)
    kind != kind_normal && force_compare_b && !tstate.match_b &&
    !at_bottom |=> $stable(wout.wave_b))
    else $error("force acted in pwm mode");

  a_force_nop_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    kind != kind_normal && force_compare_a && !tstate.match_a &&
    !at_bottom |=> $stable(wout.wave_a))
    else $error("force on a acted in pwm mode");

  a_force_toggle: assert property (
    @(posedge pclk) disable iff (!presetn)
    kind == kind_normal && out_mode_a_q == mode_toggle &&
    force_compare_a && !tstate.match_a
    |=> wout.wave_a != $past(wout.wave_a))
    else $error("forced toggle missing");

  a_force_clear_b: assert property (
    @(posedge pclk) disable iff (!presetn)
    kind == kind_normal && out_mode_b_q == mode_clear && force_compare_b
    |=> !wout.wave_b)
    else $error("forced clear missing");

  a_force_set_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    kind == kind_normal && out_mode_a_q == mode_set && force_compare_a
    |=> wout.wave_a)
    else $error("forced set missing");

  a_force_noflag: assert property (
    @(posedge pclk) disable iff (!presetn)
    force_compare_a && !tstate.match_a
    |-> !counter_clear && !match_flag_a)
    else $error("force raised flag or clear");

  a_force_read_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_en && paddr == force_off
    |-> prdata == 32'h0000_0000)
    else $error("force register read not zero");

endmodule

/* File: tb/timer_cmp_out_test.sv */
// Purpose: Self-checking bench for the compare-output block
// Assumes: Zero-wait APB, status mirrors waves, overrides and direction
// Notes:   Notes queue feeds a monitor that checks each access edge
`timescale 1ns/100ps
module timer_cmp_out_test
  import cmp_out_pkg::*;
();
  typedef struct packed {
    logic [39:0] v;
    logic [39:0] m;
  } note_t;

  localparam logic [39:0] m_rd = 40'h08FFFFFFFF;
  localparam logic [39:0] m_wr = 40'h0F00000000;
  localparam logic [39:0] m_st = 40'hF8FFFFFFFF;
  localparam logic [39:0] m_ev = 40'h0700000000;

  logic         pclk;
  logic         presetn;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [11:0]  paddr;
  logic [31:0]  pwdata;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  timer_state_t tstate;
  logic [15:0]  icr_top;
  wave_out_t    wout;
  logic         match_flag_a;
  logic         match_flag_b;
  logic         counter_clear;
  logic         probe;
  logic [31:0]  seed;
  int           bad_count;
  int           num_checks;
  logic         dn;
  logic         wa;
  logic         wb;
  logic [3:0]   sel;
  logic [1:0]   ma;
  logic [1:0]   mb;
  logic [15:0]  ca_v;
  logic [15:0]  cb_v;
  note_t        exp_q[$];

  timer_cmp_out dut (
    .pclk         (pclk),
    .presetn      (presetn),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .tstate       (tstate),
    .icr_top      (icr_top),
    .wout         (wout),
    .match_flag_a (match_flag_a),
    .match_flag_b (match_flag_b),
    .counter_clear (counter_clear)
  );

  initial begin
    pclk = 1'b0;
  end
  always #5 pclk = ~pclk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic wave_kind_t kind_of(input logic [3:0] s);
    if (s inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB}) return kind_phase;
    if (s inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF}) return kind_fast;
    return kind_normal;
  endfunction

  function automatic logic ovr(input logic [1:0] m, input logic isa);
    wave_kind_t k;
    k = kind_of(sel);
    if (m != mode_toggle) return m != mode_off;
    if (k == kind_fast) return isa && sel == wgm_toggle_fast;
    if (k == kind_phase)
      return isa && (sel == wgm_toggle_pc0 || sel == wgm_toggle_pc1);
    return isa;
  endfunction

  function automatic logic nxt(input logic cur, input logic [1:0] m,
      input logic isa, input logic hit, input logic f, input logic bot,
      input logic d, input logic eq);
    wave_kind_t k;
    k = kind_of(sel);
    if (k == kind_normal) hit = hit | f;
    if (m == mode_off) return cur;
    if (m == mode_toggle) return (hit && ovr(m, isa)) ? ~cur : cur;
    if (k == kind_fast) begin
      if (hit && !eq) return m == mode_set;
      return bot ? (m == mode_clear) : cur;
    end
    if (k == kind_phase) return hit ? (d ^ (m == mode_set)) : cur;
    return hit ? (m == mode_set) : cur;
  endfunction

  task complete_run();
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Monitor: every access edge or event probe takes the oldest note
  always @(posedge pclk) begin
    note_t       n;
    logic [39:0] obs;
    obs = {wout, pslverr, match_flag_a, match_flag_b, counter_clear, prdata};
    if ((psel & penable & pready) === 1'b1 || probe === 1'b1) begin
      num_checks++;
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("MISMATCH %0t result without note", $time);
      end else begin
        n = exp_q.pop_front();
        if ((obs & n.m) !== (n.v & n.m)) begin
          bad_count++;
          $display("MISMATCH %0t got %h want %h", $time, obs & n.m, n.v);
        end
      end
    end
  end

  task apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d,
           input logic [39:0] v, input logic [39:0] m);
    int i;
    exp_q.push_back('{v, m});
    psel    <= 1'b1;
    pwrite  <= wr_en;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      bad_count++;
      $display("MISMATCH %0t no ready", $time);
      complete_run();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d, {4'h0, e, 35'h0}, m_wr);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] d, input logic e);
    apb(1'b0, a, 32'h0, {4'h0, e, 3'h0, d}, m_rd);
  endtask

  task chk_st();
    logic oa;
    logic ob;
    oa = ovr(ma, 1'b1);
    ob = ovr(mb, 1'b0);
    apb(1'b0, status_off, 32'h0,
        {wa, wb, oa, ob, 4'h0, 27'h0, dn, ob, oa, wb, wa}, m_st);
  endtask

  task ev(input logic a, input logic b, input logic [15:0] c, input logic d);
    tstate <= '{count: c, match_a: a, match_b: b, count_down: d};
    probe  <= 1'b1;
    exp_q.push_back('{{5'h00, a, b, a && sel == 4'h4, 32'h0}, m_ev});
    wa = nxt(wa, ma, 1'b1, a, 1'b0, c == bottom_val, d, sel == 4'hF);
    wb = nxt(wb, mb, 1'b0, b, 1'b0, c == bottom_val, d,
             sel == 4'hF && cb_v == ca_v);
    dn = d;
    @(posedge pclk);
    probe  <= 1'b0;
    tstate <= '{count: 16'h0001, match_a: 1'b0, match_b: 1'b0, count_down: d};
  endtask

  task frc(input logic [1:0] f);
    wr(force_off, {28'h0, f, 2'h0}, 1'b0);
    wa = nxt(wa, ma, 1'b1, 1'b0, f[1], 1'b0, dn, 1'b0);
    wb = nxt(wb, mb, 1'b0, 1'b0, f[0], 1'b0, dn, 1'b0);
    rd(force_off, 32'h0, 1'b0);
  endtask

  initial begin
    logic [31:0] r;
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    probe   = 1'b0;
    icr_top = 16'h8000;
    tstate  = '{count: 16'h0001, match_a: 1'b0, match_b: 1'b0,
                count_down: 1'b0};
    seed    = 32'h0000AD40;
    dn = 1'b0;
    wa = 1'b0;
    wb = 1'b0;
    sel = 4'h0;
    ma = 2'h0;
    mb = 2'h0;
    ca_v = 16'h0;
    cb_v = 16'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ctrl_off, 32'h0, 1'b0);
    rd(cmp_a_off, 32'h0, 1'b0);
    chk_st();
    wr(cmp_b_off, 32'hFFFF1234, 1'b0);
    rd(cmp_b_off, 32'h00001234, 1'b0);
    wr(12'h014, 32'h000000FF, 1'b1);
    rd(12'h014, 32'h0, 1'b1);
    rd(ctrl_off, 32'h0, 1'b0);
    for (int s = 0; s < 16; s++) begin
      sel = s[3:0];
      r = rnd();
      ca_v = {9'h000, r[6:0]} | 16'h0001;
      cb_v = (sel == 4'hF) ? ca_v : ca_v ^ 16'h0040;
      wr(cmp_a_off, {16'h0, ca_v}, 1'b0);
      wr(cmp_b_off, {16'h0, cb_v}, 1'b0);
      for (int k = 0; k < 4; k++) begin
        ma = k[1:0];
        mb = ~ma;
        if ((sel == 4'h9 || sel == 4'hB) && ma[1]) ma = mode_toggle;
        wr(ctrl_off, {24'h0, mb, ma, sel}, 1'b0);
        rd(ctrl_off, {24'h0, mb, ma, sel}, 1'b0);
        chk_st();
        repeat (6) begin
          r = rnd();
          if (r[0])
            frc(r[2:1]);
          else
            ev(r[3], r[4], r[5] ? 16'h0 : {r[31:17], 1'b1},
               r[6]);
          chk_st();
        end
      end
    end
    complete_run();
  end
endmodule
